//--- inc/ofrc_pkg.sv
// constants and types for the over-temperature fault response controller
// Summary of operation
// RL1: code 00 keeps output running during fault
// RL2: code 01 runs on for programmed delay
// RL3: fault still present after delay: apply retries
// RL4: code 10 disables output, then retries
// RL5: code 11 latches off until cleared
// RL6: commanded off then on clears latch
// RL7: retry code 000 never restarts
// RL8: codes 001..011 restart one to three times
// RL9: failed retries leave output latched off
// RL10: attempts spaced by retry time units
// RL11: time code n selects two-power-n units
// RL12: codes 101, 110 restart five, six times
// RL13: code 111 retries without limit
// RL14: unit duration comes from separate setting
// RL15: attempt counter zeroed on clear or shutdown; code keeps it on a code 11 shutdown or a clear in run or delay
package ofrc_pkg;

  // register map
  localparam logic [7:0] OFRC_ACTION_ADDR  = 8'h50;
  localparam logic [7:0] OFRC_ACTION_RESET = 8'h80;

  // field positions inside the action register
  localparam int OFRC_MODE_HI  = 7;
  localparam int OFRC_MODE_LO  = 6;
  localparam int OFRC_RTRY_HI  = 5;
  localparam int OFRC_RTRY_LO  = 3;
  localparam int OFRC_TIME_HI  = 2;
  localparam int OFRC_TIME_LO  = 0;

  // retry count code that means no limit
  localparam logic [2:0] OFRC_RETRY_FOREVER = 3'h7;
  // values after reset
  localparam logic [2:0] OFRC_ATTEMPT_RESET = 3'h0;
  localparam logic [15:0] OFRC_UNIT_RESET   = 16'h0000;
  localparam logic [7:0]  OFRC_COUNT_RESET  = 8'h00;

  // response selected by bits 7:6
  typedef enum logic [1:0] {
    OFRC_IGNORE    = 2'b00,
    OFRC_RUN_DELAY = 2'b01,
    OFRC_OFF_RETRY = 2'b10,
    OFRC_OFF_LATCH = 2'b11
  } ofrc_mode_t;

  // controller states
  typedef enum logic [2:0] {
    OFRC_ST_RUN   = 3'b000,
    OFRC_ST_DELAY = 3'b001,
    OFRC_ST_WAIT  = 3'b010,
    OFRC_ST_LATCH = 3'b011,
    OFRC_ST_CMDOFF = 3'b100
  } ofrc_state_t;

endpackage : ofrc_pkg

//--- logic/ofrc_sync2.sv
// two-stage synchroniser for pins entering the clock domain
`timescale 1ns/100ps
`default_nettype none
module ofrc_sync2 #(
  parameter int   WIDTH = 1,
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_i,
  output var  logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;

  // first stage is read only by the second stage
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_ff <= {WIDTH{RST_VAL}};
      sync_o  <= {WIDTH{RST_VAL}};
    end else begin
      meta_ff <= async_i;
      sync_o  <= meta_ff;
    end
  end

endmodule : ofrc_sync2
`default_nettype wire

//--- logic/ofrc_unit_timer.sv
// delay timer counting a number of time units of programmable length
`timescale 1ns/100ps
`default_nettype none
module ofrc_unit_timer #(
  parameter int UNIT_W  = 16,
  parameter int COUNT_W = 8
) (
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_b_i,
  // control
  input  wire logic               start_i,
  input  wire logic               stop_i,
  input  wire logic [COUNT_W-1:0] units_i,
  input  wire logic [UNIT_W-1:0]  unit_cycles_i,
  // status
  output var  logic               busy_o,
  output var  logic               done_o
);

  logic [UNIT_W-1:0]  pre_ff;
  logic [COUNT_W-1:0] left_ff;
  logic               unit_end;

  // a unit of zero cycles is taken as one so the timer always ends
  assign unit_end = (pre_ff >= unit_cycles_i) || (unit_cycles_i <= UNIT_W'(1));

  // prescaler and unit counter; start restarts a running count
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pre_ff  <= '0;
      left_ff <= '0;
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (stop_i) begin
        busy_o <= 1'b0;
      end else if (start_i) begin
        pre_ff  <= UNIT_W'(1);
        left_ff <= units_i;
        busy_o  <= 1'b1;
      end else if (busy_o) begin
        if (unit_end) begin
          pre_ff  <= UNIT_W'(1);
          left_ff <= left_ff - COUNT_W'(1);
          if (left_ff <= COUNT_W'(1)) begin
            busy_o <= 1'b0;
            done_o <= 1'b1;
          end
        end else begin
          pre_ff <= pre_ff + UNIT_W'(1);
        end
      end
    end
  end

endmodule : ofrc_unit_timer
`default_nettype wire

//--- logic/ofrc_ctrl.sv
// over-temperature fault response controller top level
`timescale 1ns/100ps
`default_nettype none
module ofrc_ctrl #(
  parameter int UNIT_W = 16
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // register port from the command engine
  input  wire logic              cfg_wr_i,
  input  wire logic [7:0]        cfg_addr_i,
  input  wire logic [7:0]        cfg_wdata_i,
  output var  logic [7:0]        cfg_rdata_o,
  // time unit setting, clock cycles per delay unit
  input  wire logic [UNIT_W-1:0] unit_cycles_i,
  // fault and clearing events from logic
  input  wire logic              fault_i,
  input  wire logic              op_on_i,
  input  wire logic              clear_status_i,
  input  wire logic              clear_faults_i,
  // pins
  input  wire logic              ctrl_pin_i,
  input  wire logic              reset_pin_b_i,
  // power stage and status
  output var  logic              power_en_o,
  output var  logic              fault_flag_o,
  output var  logic              latched_o,
  output var  logic              retrying_o,
  output var  logic [2:0]        attempt_cnt_o,
  output var  logic [2:0]        state_o
);

  // code n selects 2**n delay units
  function automatic logic [7:0] units_of(input logic [2:0] code);
    units_of = 8'h01 << code;
  endfunction : units_of

  // true once the attempts made reach the allowed count
  function automatic logic retries_spent(input logic [2:0] code, input logic [2:0] done);
    retries_spent = (code != ofrc_pkg::OFRC_RETRY_FOREVER) && (done >= code);
  endfunction : retries_spent

  logic [7:0]             action_ff;
  logic                   ctrl_s;
  logic                   rst_pin_b_s;
  logic                   fault_q_ff;
  logic [2:0]             attempt_ff;
  logic [2:0]             nxt_attempt;
  ofrc_pkg::ofrc_state_t  state_ff;
  ofrc_pkg::ofrc_state_t  nxt_state;
  ofrc_pkg::ofrc_mode_t   mode;
  logic [2:0]             retry_code;
  logic [2:0]             time_code;
  logic                   cmd_on;
  logic                   clear_evt;
  logic                   tmr_start;
  logic                   tmr_stop;
  logic                   tmr_busy;
  logic                   tmr_done;
  logic                   fault_rise;

  // pins cross into the clock domain before any use
  ofrc_sync2 #(.WIDTH(1), .RST_VAL(1'b0)) u_ctrl_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i (ctrl_pin_i),
    .sync_o  (ctrl_s)
  );

  ofrc_sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_rst_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i (reset_pin_b_i),
    .sync_o  (rst_pin_b_s)
  );

  // field decode of the action setting
  assign mode       = ofrc_pkg::ofrc_mode_t'(action_ff[ofrc_pkg::OFRC_MODE_HI:ofrc_pkg::OFRC_MODE_LO]);
  assign retry_code = action_ff[ofrc_pkg::OFRC_RTRY_HI:ofrc_pkg::OFRC_RTRY_LO];
  assign time_code  = action_ff[ofrc_pkg::OFRC_TIME_HI:ofrc_pkg::OFRC_TIME_LO];

  // output wanted only while both pin and operation command say on
  assign cmd_on    = ctrl_s & op_on_i; // see RL6
  assign clear_evt = clear_status_i | clear_faults_i | ~rst_pin_b_s; // see RL5

  // action register, written by the command engine
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      action_ff <= ofrc_pkg::OFRC_ACTION_RESET;
    end else if (cfg_wr_i && (cfg_addr_i == ofrc_pkg::OFRC_ACTION_ADDR)) begin
      action_ff <= cfg_wdata_i;
    end
  end

  // readback; other addresses answer zero
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cfg_rdata_o <= 8'h00;
    end else if (cfg_addr_i == ofrc_pkg::OFRC_ACTION_ADDR) begin
      cfg_rdata_o <= action_ff;
    end else begin
      cfg_rdata_o <= 8'h00;
    end
  end

  // one timer serves both the run-on delay and the retry spacing
  ofrc_unit_timer #(.UNIT_W(UNIT_W), .COUNT_W(8)) u_timer (
    .clk_i         (clk_i),
    .rst_b_i       (rst_b_i),
    .start_i       (tmr_start),
    .stop_i        (tmr_stop),
    .units_i       (units_of(time_code)),  // see RL11
    .unit_cycles_i (unit_cycles_i),        // see RL14
    .busy_o        (tmr_busy),
    .done_o        (tmr_done)
  );

  // response sequencing
  always_comb begin
    nxt_state   = state_ff;
    nxt_attempt = attempt_ff;
    tmr_start   = 1'b0;
    tmr_stop    = 1'b0;
    unique case (state_ff)
      ofrc_pkg::OFRC_ST_RUN: begin
        // faults only matter while the output is commanded on
        if (fault_i && cmd_on) begin
          unique case (mode)
            ofrc_pkg::OFRC_IGNORE: begin
              nxt_state = ofrc_pkg::OFRC_ST_RUN; // see RL1
            end
            ofrc_pkg::OFRC_RUN_DELAY: begin
              nxt_state = ofrc_pkg::OFRC_ST_DELAY; // see RL2
              tmr_start = 1'b1;
            end
            ofrc_pkg::OFRC_OFF_RETRY: begin
              nxt_attempt = ofrc_pkg::OFRC_ATTEMPT_RESET; // see RL15
              if (retry_code == 3'h0) begin
                nxt_state = ofrc_pkg::OFRC_ST_LATCH; // see RL7
              end else begin
                nxt_state = ofrc_pkg::OFRC_ST_WAIT; // see RL4
                tmr_start = 1'b1;
              end
            end
            ofrc_pkg::OFRC_OFF_LATCH: begin
              nxt_state = ofrc_pkg::OFRC_ST_LATCH; // see RL5
            end
          endcase
        end
      end
      ofrc_pkg::OFRC_ST_DELAY: begin
        if (!cmd_on) begin
          tmr_stop  = 1'b1;
          nxt_state = ofrc_pkg::OFRC_ST_RUN;
        end else if (tmr_done) begin
          if (!fault_i) begin
            nxt_state = ofrc_pkg::OFRC_ST_RUN;
          end else if (retry_code == 3'h0) begin
            nxt_attempt = ofrc_pkg::OFRC_ATTEMPT_RESET; // see RL15
            nxt_state   = ofrc_pkg::OFRC_ST_LATCH; // see RL3
          end else begin
            nxt_attempt = ofrc_pkg::OFRC_ATTEMPT_RESET; // see RL15
            nxt_state   = ofrc_pkg::OFRC_ST_WAIT; // see RL3
            tmr_start   = 1'b1;
          end
        end else if (!tmr_busy) begin
          // an idle timer here would strand the delay, so rearm it
          tmr_start = 1'b1;
        end
      end
      ofrc_pkg::OFRC_ST_WAIT: begin
        if (clear_evt) begin
          tmr_stop    = 1'b1;
          nxt_attempt = ofrc_pkg::OFRC_ATTEMPT_RESET; // see RL15
          nxt_state   = ofrc_pkg::OFRC_ST_RUN;
        end else if (!cmd_on) begin
          tmr_stop  = 1'b1; // see RL13
          nxt_state = ofrc_pkg::OFRC_ST_CMDOFF;
        end else if (tmr_done) begin
          // saturate so the unlimited code never wraps the count
          if (attempt_ff != 3'h7) begin
            nxt_attempt = attempt_ff + 3'h1; // see RL8
          end
          if (!fault_i) begin
            nxt_state = ofrc_pkg::OFRC_ST_RUN;
          end else if (retries_spent(retry_code, attempt_ff + 3'h1)) begin
            nxt_state = ofrc_pkg::OFRC_ST_LATCH; // see RL9 see RL12
          end else begin
            tmr_start = 1'b1; // see RL10 see RL13
          end
        end else if (!tmr_busy) begin
          // same guard as the delay: never wait on a stopped timer
          tmr_start = 1'b1;
        end
      end
      ofrc_pkg::OFRC_ST_LATCH: begin
        if (clear_evt) begin
          nxt_attempt = ofrc_pkg::OFRC_ATTEMPT_RESET; // see RL15
          nxt_state   = ofrc_pkg::OFRC_ST_RUN; // see RL5
        end else if (!cmd_on) begin
          nxt_state = ofrc_pkg::OFRC_ST_CMDOFF; // see RL6
        end
      end
      ofrc_pkg::OFRC_ST_CMDOFF: begin
        if (cmd_on || clear_evt) begin
          nxt_attempt = ofrc_pkg::OFRC_ATTEMPT_RESET; // see RL15
          nxt_state   = ofrc_pkg::OFRC_ST_RUN; // see RL6
        end
      end
      default: begin
        nxt_state = ofrc_pkg::OFRC_ST_LATCH;
      end
    endcase
  end

  // response state
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_ff <= ofrc_pkg::OFRC_ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // restart attempts made in the current sequence
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      attempt_ff <= ofrc_pkg::OFRC_ATTEMPT_RESET;
    end else begin
      attempt_ff <= nxt_attempt;
    end
  end

  // power enable follows the next state so it never lags a shutdown
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      power_en_o <= 1'b0;
    end else begin
      power_en_o <= cmd_on && ((nxt_state == ofrc_pkg::OFRC_ST_RUN) ||
                               (nxt_state == ofrc_pkg::OFRC_ST_DELAY)); // see RL1 see RL2
    end
  end

  // previous fault level; resets to the idle level so no false edge follows
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      fault_q_ff <= 1'b0;
    end else begin
      fault_q_ff <= fault_i;
    end
  end

  // only a new fault edge sets the status bit, a standing level does not
  assign fault_rise = fault_i && !fault_q_ff;

  // sticky status bit; a new fault edge wins over a clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      fault_flag_o <= 1'b0;
    end else if (fault_rise) begin
      fault_flag_o <= 1'b1;
    end else if (clear_evt) begin
      fault_flag_o <= 1'b0; // see RL5
    end
  end

  // latched-off status
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      latched_o <= 1'b0;
    end else begin
      latched_o <= (nxt_state == ofrc_pkg::OFRC_ST_LATCH);
    end
  end

  // waiting-for-retry status
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      retrying_o <= 1'b0;
    end else begin
      retrying_o <= (nxt_state == ofrc_pkg::OFRC_ST_WAIT);
    end
  end

  // attempt count seen from outside
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      attempt_cnt_o <= ofrc_pkg::OFRC_ATTEMPT_RESET;
    end else begin
      attempt_cnt_o <= nxt_attempt;
    end
  end

  // state seen from outside, registered so it never glitches
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_o <= ofrc_pkg::OFRC_ST_RUN;
    end else begin
      state_o <= nxt_state;
    end
  end

endmodule : ofrc_ctrl
`default_nettype wire

//--- test/ofrc_ctrl_props.sv
// concurrent checks on the fault response controller ports
`timescale 1ns/100ps
`default_nettype none
module ofrc_ctrl_props (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_b_i,
  // register port
  input wire logic       cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  // events and pins
  input wire logic       fault_i,
  input wire logic       op_on_i,
  input wire logic       clear_status_i,
  input wire logic       clear_faults_i,
  input wire logic       ctrl_pin_i,
  input wire logic       reset_pin_b_i,
  // status
  input wire logic       power_en_o,
  input wire logic       fault_flag_o,
  input wire logic       latched_o,
  input wire logic       retrying_o,
  input wire logic [2:0] attempt_cnt_o,
  input wire logic [2:0] state_o
);
  logic [7:0]  act_ff;
  logic [11:0] hist_ff;
  logic [3:0]  now_w;
  logic        quiet;
  // shadow of the action register
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      act_ff <= ofrc_pkg::OFRC_ACTION_RESET;
    end else if (cfg_wr_i && cfg_addr_i == ofrc_pkg::OFRC_ACTION_ADDR) begin
      act_ff <= cfg_wdata_i;
    end
  end
  // pins pass synchronisers, so no clearing cause may lurk three cycles back
  assign now_w = {ctrl_pin_i, reset_pin_b_i, op_on_i, !(clear_status_i || clear_faults_i)};
  always_ff @(posedge clk_i) begin
    hist_ff <= {hist_ff[7:0], now_w};
  end
  assign quiet = (&hist_ff) && (&now_w);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_ignore_stays_on:
    assert property (state_o == 3'h0 && power_en_o && act_ff[7:6] == 2'b00 && quiet
      |=> power_en_o) else $error("output dropped in ignore mode");
  chk_disable_mode_off:
    assert property (state_o == 3'h0 && power_en_o && fault_i && act_ff[7] && quiet
      |=> !power_en_o) else $error("output not cut on fault");
  chk_latch_holds:
    assert property (latched_o && quiet |=> latched_o) else $error("latch left unprompted");
  chk_off_while_waiting:
    assert property (latched_o || retrying_o |-> !power_en_o) else $error("power on while off");
  chk_count_zero_start:
    assert property ($rose(retrying_o) |-> attempt_cnt_o == 3'h0) else $error("count not zeroed");
  chk_tries_at_latch:
    assert property ($rose(latched_o) && act_ff[7:6] == 2'b10 && act_ff[5:3] != 3'h7
      |-> attempt_cnt_o == act_ff[5:3]) else $error("wrong attempt count at latch");
  chk_forever_no_latch:
    assert property (retrying_o && act_ff[5:3] == 3'h7 && quiet |=> !latched_o)
      else $error("unlimited retry latched");
  chk_cmd_off_clears:
    assert property (latched_o && !op_on_i |-> ##[1:2] !latched_o) else $error("off kept latch");
  chk_flag_on_edge:
    assert property (fault_i && !$past(fault_i) |=> fault_flag_o) else $error("status bit not set");
  chk_read_mapped:
    assert property (cfg_addr_i == ofrc_pkg::OFRC_ACTION_ADDR |=> cfg_rdata_o == $past(act_ff))
      else $error("read data wrong");
  chk_read_unmapped:
    assert property (cfg_addr_i != ofrc_pkg::OFRC_ACTION_ADDR |=> cfg_rdata_o == 8'h00)
      else $error("unmapped read not zero");
  cover property ($rose(latched_o) && attempt_cnt_o == 3'h6);
  cover property (state_o == 3'h1 ##1 state_o != 3'h1);
  cover property (retrying_o && attempt_cnt_o == 3'h7);
endmodule : ofrc_ctrl_props
bind ofrc_ctrl ofrc_ctrl_props u_props (.clk_i, .rst_b_i, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i,
  .cfg_rdata_o, .fault_i, .op_on_i, .clear_status_i, .clear_faults_i, .ctrl_pin_i,
  .reset_pin_b_i, .power_en_o, .fault_flag_o, .latched_o, .retrying_o, .attempt_cnt_o,
  .state_o);
`default_nettype wire

//--- test/ofrc_host_model.sv
// host side model: register writes, clearing commands and pins
`timescale 1ns/100ps
`default_nettype none
module ofrc_host_model (
  // clock
  input  wire logic       clk_i,
  // register port and commands
  output var  logic       cfg_wr_o,
  output var  logic [7:0] cfg_addr_o,
  output var  logic [7:0] cfg_wdata_o,
  output var  logic       op_on_o,
  output var  logic       clr_stat_o,
  output var  logic       clr_flt_o,
  // pins
  output var  logic       ctrl_pin_o,
  output var  logic       rst_pin_b_o
);
  // commanded on from the start, address parked on the action register
  initial begin
    cfg_wr_o = 1'b0;
    cfg_addr_o = 8'h50;
    cfg_wdata_o = 8'h00;
    {op_on_o, ctrl_pin_o, rst_pin_b_o} = 3'b111;
    {clr_stat_o, clr_flt_o} = 2'b00;
  end
  // one-cycle strobe; address stays so the value reads back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cfg_wr_o <= 1'b1;
    cfg_addr_o <= a;
    cfg_wdata_o <= d;
    @(posedge clk_i);
    cfg_wr_o <= 1'b0;
    cfg_wdata_o <= ~d; // data line not left showing the last value
  endtask : wr
  // address change only, so the next cycle answers for the new address
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    cfg_addr_o <= a;
    @(posedge clk_i);
  endtask : rd
  // clearing actions: status pulse, clear-faults, reset pin, off then on by command or pin
  task automatic clr(input int k);
    @(posedge clk_i);
    case (k)
      0: clr_stat_o <= 1'b1;
      1: clr_flt_o <= 1'b1;
      2: rst_pin_b_o <= 1'b0;
      3: op_on_o <= 1'b0;
      default: ctrl_pin_o <= 1'b0;
    endcase
    @(posedge clk_i);
    {clr_stat_o, clr_flt_o} <= 2'b00;
    repeat (3) @(posedge clk_i);
    rst_pin_b_o <= 1'b1;
    ctrl_pin_o <= 1'b1;
    op_on_o <= 1'b1;
  endtask : clr
endmodule : ofrc_host_model
`default_nettype wire

//--- test/test_overtemp_fault_response_ctrl.sv
// self-checking bench for the fault response controller
`timescale 1ns/100ps
`default_nettype none
module test_overtemp_fault_response_ctrl;
  logic        clk_i, rst_b_i, fault_i, cfg_wr_i, op_on_i, ctrl_pin_i, reset_pin_b_i;
  logic        clear_status_i, clear_faults_i, power_en_o, latched_o, retrying_o, fault_flag_o;
  logic [7:0]  cfg_addr_i, cfg_wdata_i, cfg_rdata_o;
  logic [15:0] unit_cycles_i;
  logic [2:0]  attempt_cnt_o, state_o;
  int          err_total, checked;
  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  ofrc_host_model u_host (.clk_i, .cfg_wr_o(cfg_wr_i), .cfg_addr_o(cfg_addr_i),
    .cfg_wdata_o(cfg_wdata_i), .op_on_o(op_on_i), .clr_stat_o(clear_status_i),
    .clr_flt_o(clear_faults_i), .ctrl_pin_o(ctrl_pin_i), .rst_pin_b_o(reset_pin_b_i));
  ofrc_ctrl #(.UNIT_W(16)) u_dut (.clk_i, .rst_b_i, .cfg_wr_i, .cfg_addr_i, .cfg_wdata_i,
    .cfg_rdata_o, .unit_cycles_i, .fault_i, .op_on_i, .clear_status_i, .clear_faults_i,
    .ctrl_pin_i, .reset_pin_b_i, .power_en_o, .fault_flag_o, .latched_o, .retrying_o,
    .attempt_cnt_o, .state_o);
  task automatic report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // sample just after the edge so the design's updates have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic set_fault(input logic v, input logic [15:0] u);
    @(posedge clk_i);
    fault_i <= v;
    unit_cycles_i <= u;
  endtask : set_fault
  // bounded wait on power (sel 0) or latch (sel 1)
  task automatic wait_for(input logic sel, input logic v, input int lim);
    int n;
    n = 0;
    while (((sel ? latched_o : power_en_o) !== v) && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      err_total++;
      $display("BAD %0t wait ran out", $time);
      report_and_stop();
    end
  endtask : wait_for
  task automatic recover(input int k);
    set_fault(1'b0, unit_cycles_i);
    u_host.clr(k);
    wait_for(1'b0, 1'b1, 40);
    chk(attempt_cnt_o, 8'h00);
  endtask : recover
  task automatic t_reg();
    tick(1);
    chk(cfg_rdata_o, ofrc_pkg::OFRC_ACTION_RESET);
    u_host.wr(8'h51, 8'h3c);
    tick(2);
    chk(cfg_rdata_o, 8'h00);
    u_host.rd(8'h50);
    tick(1);
    chk(cfg_rdata_o, ofrc_pkg::OFRC_ACTION_RESET); // write elsewhere must not land
    u_host.wr(8'h50, 8'h3c);
    tick(2);
    chk(cfg_rdata_o, 8'h3c);
  endtask : t_reg
  task automatic t_ignore();
    u_host.wr(8'h50, 8'h00);
    set_fault(1'b1, 16'h0001);
    repeat (20) begin
      tick(1);
      chk(power_en_o, 1'b1);
    end
    chk(fault_flag_o, 1'b1);
    set_fault(1'b0, 16'h0001);
  endtask : t_ignore
  task automatic t_latch();
    u_host.wr(8'h50, 8'hc0);
    set_fault(1'b1, 16'h0001);
    wait_for(1'b1, 1'b1, 5);
    set_fault(1'b0, 16'h0001);
    tick(10);
    chk(latched_o, 1'b1);
    chk(power_en_o, 1'b0);
    recover(1);
    chk(fault_flag_o, 1'b0);
  endtask : t_latch
  // 4 units of 3 cycles: output must run on for about 12 cycles
  task automatic t_delay();
    int n;
    n = 0;
    u_host.wr(8'h50, 8'h42);
    set_fault(1'b1, 16'h0003);
    while (power_en_o === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk(n >= 12 && n <= 16, 1'b1);
    wait_for(1'b1, 1'b1, 10);
    chk(state_o, 8'h03);
    recover(2);
  endtask : t_delay
  // 4 units of 2 cycles between attempts, fault never goes away
  task automatic t_retry(input logic [2:0] code);
    int n, last;
    logic [2:0] pa;
    n = 0;
    last = 0;
    pa = 3'h0;
    u_host.wr(8'h50, {2'b10, code, 3'h2});
    set_fault(1'b1, 16'h0002);
    while (latched_o !== 1'b1 && n < 300) begin
      tick(1);
      n++;
      if (attempt_cnt_o !== pa) begin
        if (pa != 3'h0) chk((n - last) >= 8 && (n - last) <= 9, 1'b1);
        last = n;
        pa = attempt_cnt_o;
      end
    end
    wait_for(1'b1, 1'b1, 1);
    chk(latched_o, 1'b1);
    chk(attempt_cnt_o, {5'h00, code});
    chk(power_en_o, 1'b0);
    recover(code % 5);
  endtask : t_retry
  task automatic t_forever();
    u_host.wr(8'h50, 8'hb8);
    set_fault(1'b1, 16'h0001);
    tick(60);
    chk(latched_o, 1'b0);
    chk(attempt_cnt_o, 8'h07);
    chk(state_o, 8'h02);
    set_fault(1'b0, 16'h0001);
    wait_for(1'b0, 1'b1, 20);
  endtask : t_forever
  // main sequence
  initial begin
    rst_b_i = 1'b0;
    fault_i = 1'b0;
    unit_cycles_i = 16'h0001;
    err_total = 0;
    checked = 0;
    repeat (10) @(posedge clk_i);
    rst_b_i <= 1'b1;
    wait_for(1'b0, 1'b1, 20);
    t_reg();
    t_ignore();
    t_latch();
    t_delay();
    for (int c = 0; c < 7; c++) begin
      t_retry(c[2:0]);
    end
    t_forever();
    report_and_stop();
  end
endmodule : test_overtemp_fault_response_ctrl
`default_nettype wire
